/* design/flash_self_program_regs.svh */
// register offsets, field positions, key values and reset values of the flash control block
// Operation
// - upper data word is 16-bit read/write, resets to ones; high byte fourth, low third.
// - data flash writes ignore lower high byte and whole upper word.
// - segment value picks program memory or data flash; software sets it first.
// - data flash writes run in background; software polls the writing flag.
// - erase control register is write-only and always reads as zero.
// - erase control bit 1 starts sector erase, bit 0 block erase; zero means nothing.
// - one operation is permitted only after first key then second key is written.
// - the unlock is used up by one operation; repeat the keys each time.
// - other activity between the two key writes leaves the partial key intact.
// - any value but the second key after the first key discards the first key.
// - key register is write-only and exists only to guard against stray operations.
// - permit bit enables operations, locked on low-speed clock, stays set after them.
// - read-only status shows data-area writing at bit 1, clearing at bit 0, reset zero.
// - program memory operations stall the cpu, so status cannot be read then.
`ifndef FLASH_SELF_PROGRAM_REGS_SVH
`define FLASH_SELF_PROGRAM_REGS_SVH

`define ADDR_DATA_LOWER    8'h00
`define ADDR_DATA_UPPER    8'h02
`define ADDR_SEGMENT       8'h04
`define ADDR_ERASE_CTRL    8'h06
`define ADDR_UNLOCK_KEY    8'h08
`define ADDR_PERMIT        8'h0A
`define ADDR_STATUS        8'h0C

`define DATA_RESET         16'hFFFF
`define DATA_BYTE_RESET    8'hFF
`define SEGMENT_RESET      8'h00
`define DATA_FLASH_SEGMENT 8'h1F

`define KEY_FIRST          8'hFA
`define KEY_SECOND         8'hF5

`define ERASE_BLOCK_BIT    0
`define ERASE_SECTOR_BIT   1
`define STATUS_CLEAR_BIT   0
`define STATUS_WRITE_BIT   1
`define PERMIT_BIT         0

`endif

/* design/flash_self_program_pkg.sv */
// types shared by the flash self-programming control block
package flash_self_program_pkg;

  typedef enum logic [1:0] {
    key_idle,
    key_first_seen,
    key_open
  } key_state_t;

  typedef enum logic [2:0] {
    op_none,
    op_program_word,
    op_program_byte,
    op_erase_block,
    op_erase_sector
  } flash_op_t;

endpackage : flash_self_program_pkg

/* design/unlock_key_sequencer.sv */
// two-write key sequencer that permits exactly one flash operation
`timescale 1ns/100ps
`include "flash_self_program_regs.svh"

module unlock_key_sequencer (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  // key writes and consumption
  input  wire logic       key_write_i,
  input  wire logic [7:0] key_data_i,
  input  wire logic       consume_i,
  // unlock state
  output logic            unlocked_o
);

  flash_self_program_pkg::key_state_t state;

  // only key writes and consumption move the state; anything else holds it
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state <= flash_self_program_pkg::key_idle;
    end else if (consume_i) begin
      state <= flash_self_program_pkg::key_idle;
    end else if (key_write_i) begin
      case (state)
        flash_self_program_pkg::key_idle: begin
          if (key_data_i == `KEY_FIRST) begin
            state <= flash_self_program_pkg::key_first_seen;
          end
        end
        flash_self_program_pkg::key_first_seen: begin
          if (key_data_i == `KEY_SECOND) begin
            state <= flash_self_program_pkg::key_open;
          end else begin
            state <= flash_self_program_pkg::key_idle;
          end
        end
        flash_self_program_pkg::key_open: begin
          // a fresh first key restarts; other values leave the unlock standing
          if (key_data_i == `KEY_FIRST) begin
            state <= flash_self_program_pkg::key_first_seen;
          end
        end
        default: begin
          state <= flash_self_program_pkg::key_idle;
        end
      endcase
    end
  end

  assign unlocked_o = (state == flash_self_program_pkg::key_open);

endmodule : unlock_key_sequencer

/* design/flash_self_program_control.sv */
// register file and operation launcher for flash self-programming
`timescale 1ns/100ps
`include "flash_self_program_regs.svh"

module flash_self_program_control (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic [1:0]  reg_byte_en_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic [15:0]      reg_rdata_o,
  // system state
  input  wire logic        low_speed_clock_i,
  // flash array controller
  output logic             flash_op_start_o,
  output logic [2:0]       flash_op_kind_o,
  output logic [31:0]      flash_op_data_o,
  output logic [7:0]       flash_op_segment_o,
  input  wire logic        flash_op_done_i,
  // cpu control
  output logic             cpu_stall_o
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0]  program_data_first_byte;
  logic [7:0]  program_data_second_byte;
  logic [7:0]  program_data_third_byte;
  logic [7:0]  program_data_fourth_byte;
  logic [15:0] program_data_lower_word;
  logic [15:0] program_data_upper_word;
  logic [7:0]  target_segment_select;
  logic        self_update_permit_bit;
  logic        data_area_writing_flag;
  logic        data_area_clearing_flag;
  logic        program_memory_busy;
  logic [1:0]  nv_progress_status;
  logic [7:0]  self_update_permit_reg;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic wr_lower;
  logic wr_upper;
  logic wr_segment;
  logic wr_erase;
  logic wr_key;
  logic wr_permit;
  logic wr_first_byte;
  logic wr_second_byte;
  logic wr_third_byte;
  logic wr_fourth_byte;
  logic lo_lane;
  logic hi_lane;

  assign lo_lane    = reg_byte_en_i[0];
  assign hi_lane    = reg_byte_en_i[1];
  assign wr_lower   = reg_write_i && (reg_addr_i == `ADDR_DATA_LOWER);
  assign wr_upper   = reg_write_i && (reg_addr_i == `ADDR_DATA_UPPER);
  assign wr_segment = reg_write_i && (reg_addr_i == `ADDR_SEGMENT) && lo_lane;
  assign wr_erase   = reg_write_i && (reg_addr_i == `ADDR_ERASE_CTRL) && lo_lane;
  assign wr_key     = reg_write_i && (reg_addr_i == `ADDR_UNLOCK_KEY) && lo_lane;
  assign wr_permit  = reg_write_i && (reg_addr_i == `ADDR_PERMIT) && lo_lane;
  assign wr_first_byte  = wr_lower && lo_lane;
  assign wr_second_byte = wr_lower && hi_lane;
  assign wr_third_byte  = wr_upper && lo_lane;
  assign wr_fourth_byte = wr_upper && hi_lane;

  // ---------------------------------------------------------------
  // target selection
  // ---------------------------------------------------------------
  logic data_flash_target;

  assign data_flash_target = (target_segment_select == `DATA_FLASH_SEGMENT);

  // ---------------------------------------------------------------
  // unlock and permission
  // ---------------------------------------------------------------
  logic unlocked;
  logic busy;
  logic op_allowed;
  logic launch;

  assign busy       = program_memory_busy || data_area_writing_flag || data_area_clearing_flag;
  // a request while busy is dropped and leaves the unlock for the next try
  assign op_allowed = unlocked && self_update_permit_bit && !busy;

  unlock_key_sequencer u_key (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .key_write_i(wr_key),
    .key_data_i (reg_wdata_i[7:0]),
    .consume_i  (launch),
    .unlocked_o (unlocked)
  );

  // ---------------------------------------------------------------
  // request detection
  // ---------------------------------------------------------------
  logic req_program_word;
  logic req_program_byte;
  logic req_erase_block;
  logic req_erase_sector;
  flash_self_program_pkg::flash_op_t next_kind;

  // program memory starts on the fourth byte landing
  assign req_program_word = wr_upper && hi_lane && !data_flash_target;
  // data flash starts on the first byte landing
  assign req_program_byte = wr_lower && lo_lane && data_flash_target;

  // both trigger bits at once is not a defined code, so it does nothing
  assign req_erase_block  = wr_erase && reg_wdata_i[`ERASE_BLOCK_BIT]
                            && !reg_wdata_i[`ERASE_SECTOR_BIT];
  assign req_erase_sector = wr_erase && reg_wdata_i[`ERASE_SECTOR_BIT]
                            && !reg_wdata_i[`ERASE_BLOCK_BIT];

  always_comb begin
    if (req_program_word) begin
      next_kind = flash_self_program_pkg::op_program_word;
    end else if (req_program_byte) begin
      next_kind = flash_self_program_pkg::op_program_byte;
    end else if (req_erase_block) begin
      next_kind = flash_self_program_pkg::op_erase_block;
    end else if (req_erase_sector) begin
      next_kind = flash_self_program_pkg::op_erase_sector;
    end else begin
      next_kind = flash_self_program_pkg::op_none;
    end
  end

  assign launch = op_allowed && (next_kind != flash_self_program_pkg::op_none);

  // ---------------------------------------------------------------
  // data registers
  // ---------------------------------------------------------------
  // one register per byte lane, so a byte write leaves its neighbour alone
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      program_data_first_byte <= `DATA_BYTE_RESET;
    end else if (wr_first_byte) begin
      program_data_first_byte <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      program_data_second_byte <= `DATA_BYTE_RESET;
    end else if (wr_second_byte) begin
      program_data_second_byte <= reg_wdata_i[15:8];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      program_data_third_byte <= `DATA_BYTE_RESET;
    end else if (wr_third_byte) begin
      program_data_third_byte <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      program_data_fourth_byte <= `DATA_BYTE_RESET;
    end else if (wr_fourth_byte) begin
      program_data_fourth_byte <= reg_wdata_i[15:8];
    end
  end

  assign program_data_lower_word = {program_data_second_byte, program_data_first_byte};
  assign program_data_upper_word = {program_data_fourth_byte, program_data_third_byte};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      target_segment_select <= `SEGMENT_RESET;
    end else if (wr_segment) begin
      target_segment_select <= reg_wdata_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // permit bit
  // ---------------------------------------------------------------
  // held through completed operations; only a software write or reset clears it
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      self_update_permit_bit <= 1'b0;
    end else if (wr_permit && !low_speed_clock_i) begin
      self_update_permit_bit <= reg_wdata_i[`PERMIT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // operation launch to the array controller
  // ---------------------------------------------------------------
  // the word being written is merged in, so the launch sees this cycle's bytes
  logic [31:0] next_op_data;

  always_comb begin
    next_op_data = {program_data_upper_word, program_data_lower_word};
    if (next_kind == flash_self_program_pkg::op_program_word) begin
      next_op_data[31:24] = reg_wdata_i[15:8];
      if (lo_lane) begin
        next_op_data[23:16] = reg_wdata_i[7:0];
      end
    end else if (next_kind == flash_self_program_pkg::op_program_byte) begin
      // only the first byte carries; the rest is sent as erased ones
      next_op_data = {24'hFFFFFF, reg_wdata_i[7:0]};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flash_op_start_o <= 1'b0;
    end else begin
      flash_op_start_o <= launch;
    end
  end

  // held until the next launch, so the array may sample them at leisure
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flash_op_kind_o <= 3'h0;
    end else if (launch) begin
      flash_op_kind_o <= next_kind;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flash_op_data_o <= 32'hFFFFFFFF;
    end else if (launch) begin
      flash_op_data_o <= next_op_data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flash_op_segment_o <= 8'h00;
    end else if (launch) begin
      flash_op_segment_o <= target_segment_select;
    end
  end

  // ---------------------------------------------------------------
  // progress tracking
  // ---------------------------------------------------------------
  logic launch_program_memory;
  logic launch_data_write;
  logic launch_data_erase;

  assign launch_program_memory = launch && !data_flash_target;
  assign launch_data_write     = launch && data_flash_target
                                 && (next_kind == flash_self_program_pkg::op_program_byte);
  assign launch_data_erase     = launch && data_flash_target
                                 && (next_kind != flash_self_program_pkg::op_program_byte);

  // launch and done cannot collide: launch needs an idle block
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      program_memory_busy <= 1'b0;
    end else if (launch_program_memory) begin
      program_memory_busy <= 1'b1;
    end else if (flash_op_done_i) begin
      program_memory_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      data_area_writing_flag <= 1'b0;
    end else if (launch_data_write) begin
      data_area_writing_flag <= 1'b1;
    end else if (flash_op_done_i) begin
      data_area_writing_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      data_area_clearing_flag <= 1'b0;
    end else if (launch_data_erase) begin
      data_area_clearing_flag <= 1'b1;
    end else if (flash_op_done_i) begin
      data_area_clearing_flag <= 1'b0;
    end
  end

  // the stall rises with a program memory launch pulse and drops with completion
  assign cpu_stall_o = program_memory_busy;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [15:0] next_rdata;

  // spare bits of both views read as zero
  assign nv_progress_status     = {data_area_writing_flag, data_area_clearing_flag};
  assign self_update_permit_reg = {7'h00, self_update_permit_bit};

  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr_i)
      `ADDR_DATA_LOWER: begin
        next_rdata = program_data_lower_word;
      end
      `ADDR_DATA_UPPER: begin
        next_rdata = program_data_upper_word;
      end
      `ADDR_SEGMENT: begin
        next_rdata = {8'h00, target_segment_select};
      end
      `ADDR_ERASE_CTRL: begin
        next_rdata = 16'h0000;
      end
      `ADDR_UNLOCK_KEY: begin
        next_rdata = 16'h0000;
      end
      `ADDR_PERMIT: begin
        next_rdata = {8'h00, self_update_permit_reg};
      end
      `ADDR_STATUS: begin
        next_rdata = {14'h0000, nv_progress_status};
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_read_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule : flash_self_program_control

/* tb/flash_self_program_asserts.sv */
// concurrent checks on the flash self-programming control ports
`timescale 1ns/100ps
`include "flash_self_program_regs.svh"

module flash_self_program_asserts (
  // clock, reset and register port
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [1:0]  reg_byte_en_i,
  input wire logic        reg_write_i,
  input wire logic        reg_read_i,
  input wire logic [15:0] reg_rdata_o,
  // system and flash side
  input wire logic        low_speed_clock_i,
  input wire logic        flash_op_start_o,
  input wire logic [2:0]  flash_op_kind_o,
  input wire logic [31:0] flash_op_data_o,
  input wire logic [7:0]  flash_op_segment_o,
  input wire logic        flash_op_done_i,
  input wire logic        cpu_stall_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking

  a_erase_reads_zero: assert property (disable iff (reset_i)
    reg_read_i && reg_addr_i == `ADDR_ERASE_CTRL |=> reg_rdata_o == 16'h0000)
    else $error("erase control read not zero");
  a_key_reads_zero: assert property (disable iff (reset_i)
    reg_read_i && reg_addr_i == `ADDR_UNLOCK_KEY |=> reg_rdata_o == 16'h0000)
    else $error("key register read not zero");
  a_status_spare_bits: assert property (disable iff (reset_i)
    reg_read_i && reg_addr_i == `ADDR_STATUS |=> reg_rdata_o[15:2] == 14'h0000)
    else $error("status spare bits set");
  a_start_from_write: assert property (disable iff (reset_i)
    flash_op_start_o |-> $past(reg_write_i))
    else $error("launch without a trigger write");
  a_start_one_shot: assert property (disable iff (reset_i)
    flash_op_start_o |=> !flash_op_start_o)
    else $error("launch pulse longer than one cycle");
  a_word_trigger: assert property (disable iff (reset_i)
    flash_op_start_o && flash_op_kind_o == 3'd1 |-> $past(reg_addr_i) == `ADDR_DATA_UPPER
    && $past(reg_byte_en_i[1]) && cpu_stall_o && flash_op_segment_o != 8'h1F)
    else $error("word program launched wrongly");
  a_byte_trigger: assert property (disable iff (reset_i)
    flash_op_start_o && flash_op_kind_o == 3'd2 |-> $past(reg_addr_i) == `ADDR_DATA_LOWER
    && $past(reg_byte_en_i[0]) && flash_op_data_o == {24'hFFFFFF, $past(reg_wdata_i[7:0])}
    && !cpu_stall_o && flash_op_segment_o == 8'h1F)
    else $error("byte program launched wrongly");
  a_erase_code: assert property (disable iff (reset_i)
    flash_op_start_o && flash_op_kind_o inside {3'd3, 3'd4} |->
    $past(reg_addr_i) == `ADDR_ERASE_CTRL
    && $past(reg_wdata_i[1:0]) == ((flash_op_kind_o == 3'd3) ? 2'b01 : 2'b10))
    else $error("erase kind does not match code");
  a_stall_release: assert property (disable iff (reset_i)
    flash_op_done_i |=> !cpu_stall_o)
    else $error("stall held after done");
  // no disable here: the reset itself is the cause
  a_reset_quiet: assert property (reset_i |=> !flash_op_start_o && !cpu_stall_o)
    else $error("activity out of reset");

  c_word: cover property (flash_op_start_o && flash_op_kind_o == 3'd1);
  c_byte: cover property (flash_op_start_o && flash_op_kind_o == 3'd2);
  c_sector: cover property (flash_op_start_o && flash_op_kind_o == 3'd4);
endmodule : flash_self_program_asserts

bind flash_self_program_control flash_self_program_asserts u_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_byte_en_i(reg_byte_en_i), .reg_write_i(reg_write_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .low_speed_clock_i(low_speed_clock_i),
  .flash_op_start_o(flash_op_start_o), .flash_op_kind_o(flash_op_kind_o),
  .flash_op_data_o(flash_op_data_o), .flash_op_segment_o(flash_op_segment_o),
  .flash_op_done_i(flash_op_done_i), .cpu_stall_o(cpu_stall_o));

/* tb/tb_top.sv */
// self-checking bench for the flash self-programming control block
`timescale 1ns/100ps
`include "flash_self_program_regs.svh"

module tb_top;
  logic        clk_sys_i, reset_i, reg_write_i, reg_read_i;
  logic        low_speed_clock_i, flash_op_done_i, flash_op_start_o, cpu_stall_o;
  logic [7:0]  reg_addr_i, flash_op_segment_o;
  logic [15:0] reg_wdata_i, reg_rdata_o, dl, du;
  logic [1:0]  reg_byte_en_i;
  logic [2:0]  flash_op_kind_o;
  logic [31:0] flash_op_data_o;
  logic [15:0] rq[$];
  logic [43:0] lq[$];
  logic [43:0] e;
  logic        rd_seen;
  int          fails, cmp_count, seed;

  flash_self_program_control dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_byte_en_i(reg_byte_en_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .low_speed_clock_i(low_speed_clock_i), .flash_op_start_o(flash_op_start_o),
    .flash_op_kind_o(flash_op_kind_o), .flash_op_data_o(flash_op_data_o),
    .flash_op_segment_o(flash_op_segment_o), .flash_op_done_i(flash_op_done_i),
    .cpu_stall_o(cpu_stall_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_byte_en_i <= be;
    reg_write_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    rq.push_back(x);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_read_i <= 1'b0;
  endtask : rd

  task automatic keys();
    wr(`ADDR_UNLOCK_KEY, {8'h00, `KEY_FIRST}, 2'b01);
    wr(`ADDR_UNLOCK_KEY, {8'h00, `KEY_SECOND}, 2'b01);
  endtask : keys

  // the array side answers a few cycles late, never instantly
  task automatic done();
    repeat (3) @(posedge clk_sys_i);
    flash_op_done_i <= 1'b1;
    @(posedge clk_sys_i);
    flash_op_done_i <= 1'b0;
  endtask : done

  task automatic pulse_reset();
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
  endtask : pulse_reset

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // erase launches carry no defined data, so bit 43 masks it
  always @(posedge clk_sys_i) begin
    if (rd_seen) chk(reg_rdata_o, rq.pop_front());
    if (!reset_i && flash_op_start_o) begin
      if (lq.size() == 0) chk(64'h1, 64'h0);
      else begin
        e = lq.pop_front();
        chk({e[43], flash_op_kind_o, flash_op_data_o & {32{e[43]}}, flash_op_segment_o}, e);
      end
    end
    rd_seen <= reg_read_i;
  end

  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    seed = 32'h2fbf;
    {reset_i, reg_write_i, reg_read_i, low_speed_clock_i, flash_op_done_i, rd_seen} = 6'h20;
    {reg_addr_i, reg_wdata_i, reg_byte_en_i} = 26'h0;
    pulse_reset();
    rd(`ADDR_DATA_UPPER, 16'hFFFF);
    rd(`ADDR_DATA_LOWER, 16'hFFFF);
    rd(`ADDR_STATUS, 16'h0000);
    rd(`ADDR_ERASE_CTRL, 16'h0000);
    rd(`ADDR_UNLOCK_KEY, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(`ADDR_DATA_UPPER, 16'hA55A, 2'b10);
    rd(`ADDR_DATA_UPPER, 16'hA5FF);
    low_speed_clock_i <= 1'b1;
    wr(`ADDR_PERMIT, 16'h0001, 2'b01);
    rd(`ADDR_PERMIT, 16'h0000);
    low_speed_clock_i <= 1'b0;
    wr(`ADDR_PERMIT, 16'h0001, 2'b01);
    wr(`ADDR_SEGMENT, 16'h0003, 2'b01);
    keys();
    lq.push_back({1'b0, 3'd4, 32'h0, 8'h03});
    wr(`ADDR_ERASE_CTRL, 16'h0002, 2'b01);
    done();
    {du, dl} = $random(seed);
    keys();
    wr(`ADDR_DATA_LOWER, dl, 2'b11);
    lq.push_back({1'b1, 3'd1, du, dl, 8'h03});
    wr(`ADDR_DATA_UPPER, du, 2'b11);
    @(posedge clk_sys_i);
    #1 chk(cpu_stall_o, 1'b1);
    done();
    #1 chk(cpu_stall_o, 1'b0);
    rd(`ADDR_PERMIT, 16'h0001);
    wr(`ADDR_DATA_UPPER, du, 2'b11);
    wr(`ADDR_UNLOCK_KEY, {8'h00, `KEY_FIRST}, 2'b01);
    wr(`ADDR_UNLOCK_KEY, 16'h0000, 2'b01);
    wr(`ADDR_UNLOCK_KEY, {8'h00, `KEY_SECOND}, 2'b01);
    wr(`ADDR_ERASE_CTRL, 16'h0002, 2'b01);
    wr(`ADDR_UNLOCK_KEY, {8'h00, `KEY_FIRST}, 2'b01);
    wr(`ADDR_SEGMENT, 16'h0003, 2'b01);
    rd(`ADDR_DATA_LOWER, dl);
    wr(`ADDR_UNLOCK_KEY, {8'h00, `KEY_SECOND}, 2'b01);
    wr(`ADDR_ERASE_CTRL, 16'h0000, 2'b01);
    wr(`ADDR_ERASE_CTRL, 16'h0003, 2'b01);
    lq.push_back({1'b0, 3'd3, 32'h0, 8'h03});
    wr(`ADDR_ERASE_CTRL, 16'h0001, 2'b01);
    done();
    keys();
    lq.push_back({1'b0, 3'd4, 32'h0, 8'h03});
    wr(`ADDR_ERASE_CTRL, 16'h0002, 2'b01);
    done();
    wr(`ADDR_SEGMENT, {8'h00, `DATA_FLASH_SEGMENT}, 2'b01);
    keys();
    dl = 16'($random(seed));
    lq.push_back({1'b1, 3'd2, 24'hFFFFFF, dl[7:0], 8'h1F});
    wr(`ADDR_DATA_LOWER, dl, 2'b01);
    rd(`ADDR_STATUS, 16'h0002);
    done();
    rd(`ADDR_STATUS, 16'h0000);
    keys();
    pulse_reset();
    wr(`ADDR_PERMIT, 16'h0001, 2'b01);
    wr(`ADDR_DATA_UPPER, du, 2'b11);
    repeat (4) @(posedge clk_sys_i);
    chk(lq.size(), 0);
    chk(rq.size(), 0);
    print_verdict();
  end
endmodule : tb_top
